//--- src/pstls_defs.svh
`ifndef PSTLS_DEFS_SVH
`define PSTLS_DEFS_SVH

// widths
`define PSTLS_AW 8
`define PSTLS_SW 16
`define PSTLS_TW 9
`define PSTLS_NPRESET 7

// register byte offsets
`define PSTLS_OFF_CTRL 8'h00
`define PSTLS_OFF_PRESET_BASE 8'h04
`define PSTLS_OFF_STEP 8'h04
`define PSTLS_OFF_FWD_INT 8'h20
`define PSTLS_OFF_REV_INT 8'h24
`define PSTLS_OFF_FWD_EXT 8'h28
`define PSTLS_OFF_REV_EXT 8'h2C
`define PSTLS_OFF_MAX_SPD 8'h30
`define PSTLS_OFF_MAX_TRQ 8'h34
`define PSTLS_OFF_STATUS 8'h38

// control and status fields
`define PSTLS_CTRL_DIGIT_MSB 3
`define PSTLS_CTRL_DIR_BIT 4
`define PSTLS_ST_SEL_MSB 2
`define PSTLS_ST_MODE_LSB 4
`define PSTLS_ST_MODE_MSB 6
`define PSTLS_ST_FWD_BIT 8
`define PSTLS_ST_REV_BIT 9

// control-mode digit codes
`define PSTLS_DIGIT_PRESET 4'h3
`define PSTLS_DIGIT_ASPEED 4'h4
`define PSTLS_DIGIT_POSITION 4'h5
`define PSTLS_DIGIT_TORQUE 4'h6

// torque cap slots
`define PSTLS_TC_FWD_INT 2'h0
`define PSTLS_TC_REV_INT 2'h1
`define PSTLS_TC_FWD_EXT 2'h2
`define PSTLS_TC_REV_EXT 2'h3

// setting ranges
`define PSTLS_SPD_LIMIT 16'h1770
`define PSTLS_TRQ_LIMIT 9'h12C

// reset values
`define PSTLS_RST_DIGIT 4'h3
`define PSTLS_RST_PRESET1 16'h0064
`define PSTLS_RST_PRESET2 16'h00C8
`define PSTLS_RST_PRESET3 16'h012C
`define PSTLS_RST_PRESET4 16'hFF9C
`define PSTLS_RST_PRESET5 16'hFF38
`define PSTLS_RST_PRESET6 16'hFED4
`define PSTLS_RST_PRESET7 16'h0000
`define PSTLS_RST_TCAP_INT 9'h12C
`define PSTLS_RST_TCAP_EXT 9'h064
`define PSTLS_RST_MAX_SPD 16'h1770
`define PSTLS_RST_MAX_TRQ 9'h12C

`endif

//--- src/pstls_pkg.sv
`include "pstls_defs.svh"

package pstls_pkg;

  typedef enum logic [2:0] {
    PSTLS_ZERO,
    PSTLS_PRESET,
    PSTLS_POSITION,
    PSTLS_ASPEED,
    PSTLS_TORQUE,
    PSTLS_OTHER
  } pstls_mode_t;

  typedef struct packed {
    logic boot;
    logic [3:0] mode_digit;
    logic dir_rev;
    logic [`PSTLS_NPRESET-1:0][`PSTLS_SW-1:0] preset;
    logic [3:0][`PSTLS_TW-1:0] tcap;
    logic [`PSTLS_SW-1:0] max_spd;
    logic [`PSTLS_TW-1:0] max_trq;
    logic [31:0] prdata;
    logic [`PSTLS_SW-1:0] spd_ref;
    pstls_mode_t mode;
    logic [`PSTLS_TW-1:0] fwd_lim;
    logic [`PSTLS_TW-1:0] rev_lim;
    logic [`PSTLS_SW-1:0] trq_out;
  } pstls_state_t;

endpackage

//--- src/pstls_sat.sv
// symmetric-or-not saturation of a signed value to [-neg_lim, +pos_lim]
module pstls_sat #(
  parameter int W = 16,
  parameter int LW = 16
) (
  // value in
  input wire logic signed [W-1:0] val,
  // bounds, magnitudes
  input wire logic [LW-1:0] pos_lim,
  input wire logic [LW-1:0] neg_lim,
  // value out
  output logic signed [W-1:0] res
);
  logic signed [W+1:0] v;
  logic signed [W+1:0] p;
  logic signed [W+1:0] n;

  always_comb begin
    v = (W+2)'(val);
    p = $signed({{(W+2-LW){1'b0}}, pos_lim});
    n = -$signed({{(W+2-LW){1'b0}}, neg_lim});
    if (v > p) begin
      res = p[W-1:0];
    end else if (v < n) begin
      res = n[W-1:0];
    end else begin
      res = val;
    end
  end
endmodule // pstls_sat

//--- src/pstls_top.sv
// Functional notes
// - seven signed preset speeds, range -6000..6000 rpm, writes act at once
// - presets one to three reset to 100, 200, 300 rpm
// - presets four to six reset to -100, -200, -300 rpm
// - a preset above motor maximum speed is replaced by that maximum
// - mode digit 3: presets by contacts, zero speed when none selected
// - three selects form binary index, msb select on top; 0 is zero speed
// - all select inputs are active low
// - mode digits 4, 5, 6 switch mode when all three selects are off
// - digit 5 with all selects off follows pulse-train position reference
// - forward and reverse internal torque caps, 0..300 percent, applied while the matching limit select is off
// - forward internal torque cap resets to 300 percent
// - a torque cap above motor maximum torque is replaced by that maximum
// - forward and reverse external caps, 0..300 percent, reset to 100
// - forward limit select on picks external forward cap, else internal
// - reverse limit select on picks external reverse cap, else internal
// - direction bit 0 means counter-clockwise is forward
//
// The implementer's own choices: the APB register port and the register addresses.
`include "pstls_defs.svh"

module pstls_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PSTLS_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // contact selects
  input wire logic preset_select_msb_n,
  input wire logic fwd_limit_select_n,
  input wire logic rev_limit_select_n,
  // torque path
  input wire logic signed [`PSTLS_SW-1:0] torque_cmd_in,
  output logic signed [`PSTLS_SW-1:0] torque_cmd_out,
  // references and limits
  output logic signed [`PSTLS_SW-1:0] speed_ref,
  output pstls_pkg::pstls_mode_t ctrl_mode,
  output logic [`PSTLS_TW-1:0] fwd_torque_limit,
  output logic [`PSTLS_TW-1:0] rev_torque_limit
);
  pstls_pkg::pstls_state_t q;
  pstls_pkg::pstls_state_t d;

  logic [2:0] sel;
  logic fwd_on;
  logic rev_on;
  logic [2:0] idx;
  logic [3:0] slot;
  logic rhit;
  logic [31:0] rdata;
  logic [31:0] status;
  logic [`PSTLS_TW-1:0] fwd_raw;
  logic [`PSTLS_TW-1:0] rev_raw;
  logic [`PSTLS_TW-1:0] fwd_lim_d;
  logic [`PSTLS_TW-1:0] rev_lim_d;
  logic signed [`PSTLS_SW-1:0] spd_sat;
  logic signed [`PSTLS_SW-1:0] trq_sat;
  logic wr_en;

  // returns {hit, index} for a preset register address
  function automatic logic [3:0] preset_slot(input logic [`PSTLS_AW-1:0] a);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < `PSTLS_NPRESET; i++) begin
      if (a == `PSTLS_AW'(`PSTLS_OFF_PRESET_BASE + i * `PSTLS_OFF_STEP)) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  // written speeds saturate to the settable range
  function automatic logic [`PSTLS_SW-1:0] wr_speed(input logic [31:0] w);
    logic signed [31:0] lim;
    lim = $signed({16'h0000, `PSTLS_SPD_LIMIT});
    if ($signed(w) > lim) begin
      return `PSTLS_SPD_LIMIT;
    end else if ($signed(w) < -lim) begin
      return `PSTLS_SW'(-lim);
    end
    return w[`PSTLS_SW-1:0];
  endfunction

  function automatic logic [`PSTLS_TW-1:0] wr_torque(input logic [31:0] w);
    if (w > {23'h00_0000, `PSTLS_TRQ_LIMIT}) begin
      return `PSTLS_TRQ_LIMIT;
    end
    return w[`PSTLS_TW-1:0];
  endfunction

  function automatic logic [`PSTLS_TW-1:0] tmin(input logic [`PSTLS_TW-1:0] a,
                                                input logic [`PSTLS_TW-1:0] b);
    return (a > b) ? b : a;
  endfunction

  // contacts are low-true; the reverse limit select is the index lsb
  assign sel = {~preset_select_msb_n, ~fwd_limit_select_n, ~rev_limit_select_n};
  assign fwd_on = ~fwd_limit_select_n;
  assign rev_on = ~rev_limit_select_n;
  assign idx = (sel == 3'h0) ? 3'h0 : 3'(sel - 3'h1);
  assign slot = preset_slot(paddr);
  assign wr_en = psel & penable & pwrite;

  // source selection follows the contacts with no qualification, so the host
  // keeps other functions off these terminals while limits are in use
  assign fwd_raw = fwd_on ? q.tcap[`PSTLS_TC_FWD_EXT] : q.tcap[`PSTLS_TC_FWD_INT];
  assign rev_raw = rev_on ? q.tcap[`PSTLS_TC_REV_EXT] : q.tcap[`PSTLS_TC_REV_INT];
  assign fwd_lim_d = tmin(fwd_raw, q.max_trq);
  assign rev_lim_d = tmin(rev_raw, q.max_trq);

  pstls_sat #(
    .W(`PSTLS_SW),
    .LW(`PSTLS_SW)
  ) u_spd_sat (
    .val(q.preset[idx]),
    .pos_lim(q.max_spd),
    .neg_lim(q.max_spd),
    .res(spd_sat)
  );

  pstls_sat #(
    .W(`PSTLS_SW),
    .LW(`PSTLS_TW)
  ) u_trq_sat (
    .val(torque_cmd_in),
    .pos_lim(fwd_lim_d),
    .neg_lim(rev_lim_d),
    .res(trq_sat)
  );

  always_comb begin
    status = 32'h0000_0000;
    status[`PSTLS_ST_SEL_MSB:0] = sel;
    status[`PSTLS_ST_MODE_MSB:`PSTLS_ST_MODE_LSB] = q.mode;
    status[`PSTLS_ST_FWD_BIT] = fwd_on;
    status[`PSTLS_ST_REV_BIT] = rev_on;
    rhit = 1'b1;
    rdata = 32'h0000_0000;
    case (paddr)
      `PSTLS_OFF_CTRL: rdata = {27'h000_0000, q.dir_rev, q.mode_digit};
      `PSTLS_OFF_FWD_INT: rdata = {23'h00_0000, q.tcap[`PSTLS_TC_FWD_INT]};
      `PSTLS_OFF_REV_INT: rdata = {23'h00_0000, q.tcap[`PSTLS_TC_REV_INT]};
      `PSTLS_OFF_FWD_EXT: rdata = {23'h00_0000, q.tcap[`PSTLS_TC_FWD_EXT]};
      `PSTLS_OFF_REV_EXT: rdata = {23'h00_0000, q.tcap[`PSTLS_TC_REV_EXT]};
      `PSTLS_OFF_MAX_SPD: rdata = {16'h0000, q.max_spd};
      `PSTLS_OFF_MAX_TRQ: rdata = {23'h00_0000, q.max_trq};
      `PSTLS_OFF_STATUS: rdata = status;
      default: begin
        rhit = slot[3];
        if (slot[3]) begin
          rdata = {{16{q.preset[slot[2:0]][`PSTLS_SW-1]}}, q.preset[slot[2:0]]};
        end
      end
    endcase
  end

  always_comb begin
    d = q;
    d.boot = 1'b0;
    // read data is captured in the setup phase so the access phase needs no wait
    if (psel && !penable) begin
      d.prdata = rdata;
    end
    if (wr_en && rhit) begin
      case (paddr)
        `PSTLS_OFF_CTRL: begin
          d.mode_digit = pwdata[`PSTLS_CTRL_DIGIT_MSB:0];
          d.dir_rev = pwdata[`PSTLS_CTRL_DIR_BIT];
        end
        `PSTLS_OFF_FWD_INT: d.tcap[`PSTLS_TC_FWD_INT] = wr_torque(pwdata);
        `PSTLS_OFF_REV_INT: d.tcap[`PSTLS_TC_REV_INT] = wr_torque(pwdata);
        `PSTLS_OFF_FWD_EXT: d.tcap[`PSTLS_TC_FWD_EXT] = wr_torque(pwdata);
        `PSTLS_OFF_REV_EXT: d.tcap[`PSTLS_TC_REV_EXT] = wr_torque(pwdata);
        `PSTLS_OFF_MAX_SPD: d.max_spd = pwdata[`PSTLS_SW-1:0];
        `PSTLS_OFF_MAX_TRQ: d.max_trq = pwdata[`PSTLS_TW-1:0];
        `PSTLS_OFF_STATUS: d.max_trq = q.max_trq;
        default: d.preset[slot[2:0]] = wr_speed(pwdata);
      endcase
    end
    // mode and speed reference
    d.spd_ref = '0;
    case (q.mode_digit)
      `PSTLS_DIGIT_PRESET: d.mode = (sel == 3'h0) ? pstls_pkg::PSTLS_ZERO
                                                  : pstls_pkg::PSTLS_PRESET;
      `PSTLS_DIGIT_ASPEED: d.mode = (sel == 3'h0) ? pstls_pkg::PSTLS_ASPEED
                                                  : pstls_pkg::PSTLS_PRESET;
      `PSTLS_DIGIT_POSITION: d.mode = (sel == 3'h0) ? pstls_pkg::PSTLS_POSITION
                                                    : pstls_pkg::PSTLS_PRESET;
      `PSTLS_DIGIT_TORQUE: d.mode = (sel == 3'h0) ? pstls_pkg::PSTLS_TORQUE
                                                  : pstls_pkg::PSTLS_PRESET;
      default: d.mode = pstls_pkg::PSTLS_OTHER;
    endcase
    if (d.mode == pstls_pkg::PSTLS_PRESET) begin
      // sign flip only when clockwise is declared forward
      d.spd_ref = q.dir_rev ? `PSTLS_SW'(-spd_sat) : spd_sat;
    end
    d.fwd_lim = fwd_lim_d;
    d.rev_lim = rev_lim_d;
    d.trq_out = trq_sat;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.boot <= 1'b1;
      q.mode_digit <= `PSTLS_RST_DIGIT;
      q.preset[0] <= `PSTLS_RST_PRESET1;
      q.preset[1] <= `PSTLS_RST_PRESET2;
      q.preset[2] <= `PSTLS_RST_PRESET3;
      q.preset[3] <= `PSTLS_RST_PRESET4;
      q.preset[4] <= `PSTLS_RST_PRESET5;
      q.preset[5] <= `PSTLS_RST_PRESET6;
      q.preset[6] <= `PSTLS_RST_PRESET7;
      q.tcap[`PSTLS_TC_FWD_INT] <= `PSTLS_RST_TCAP_INT;
      q.tcap[`PSTLS_TC_REV_INT] <= `PSTLS_RST_TCAP_INT;
      q.tcap[`PSTLS_TC_FWD_EXT] <= `PSTLS_RST_TCAP_EXT;
      q.tcap[`PSTLS_TC_REV_EXT] <= `PSTLS_RST_TCAP_EXT;
      q.max_spd <= `PSTLS_RST_MAX_SPD;
      q.max_trq <= `PSTLS_RST_MAX_TRQ;
      q.mode <= pstls_pkg::PSTLS_ZERO;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~rhit;
  assign speed_ref = q.spd_ref;
  assign ctrl_mode = q.mode;
  assign fwd_torque_limit = q.fwd_lim;
  assign rev_torque_limit = q.rev_lim;
  assign torque_cmd_out = q.trq_out;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wr_preset1;
    wr_en && paddr == `PSTLS_OFF_PRESET_BASE &&
      $signed(pwdata) <= $signed({16'h0000, `PSTLS_SPD_LIMIT}) &&
      $signed(pwdata) >= -$signed({16'h0000, `PSTLS_SPD_LIMIT});
  endsequence
  sequence s_no_select(logic [3:0] dig);
    q.mode_digit == dig && sel == 3'h0;
  endsequence

  property p_preset_write;
    s_wr_preset1 |=> q.preset[0] == $past(pwdata[`PSTLS_SW-1:0]);
  endproperty
  a_preset_write: assert property (p_preset_write) else $error("preset write lost");

  property p_boot_pos;
    q.boot |-> q.preset[0] == `PSTLS_RST_PRESET1 && q.preset[1] == `PSTLS_RST_PRESET2
               && q.preset[2] == `PSTLS_RST_PRESET3;
  endproperty
  a_boot_pos: assert property (p_boot_pos) else $error("positive preset defaults");

  property p_boot_neg;
    q.boot |-> q.preset[3] == `PSTLS_RST_PRESET4 && q.preset[4] == `PSTLS_RST_PRESET5
               && q.preset[5] == `PSTLS_RST_PRESET6;
  endproperty
  a_boot_neg: assert property (p_boot_neg) else $error("negative preset defaults");

  property p_spd_bound;
    ##1 (q.spd_ref[`PSTLS_SW-1] ? `PSTLS_SW'(-q.spd_ref) : q.spd_ref) <= $past(q.max_spd);
  endproperty
  a_spd_bound: assert property (p_spd_bound) else $error("speed above motor max");

  property p_zero_ref;
    s_no_select(`PSTLS_DIGIT_PRESET) |=> q.spd_ref == '0 && q.mode == pstls_pkg::PSTLS_ZERO;
  endproperty
  a_zero_ref: assert property (p_zero_ref) else $error("zero reference missing");

  property p_index_pick;
    q.mode_digit == `PSTLS_DIGIT_PRESET && sel == 3'h1 && !q.dir_rev &&
      $signed(q.preset[0]) >= 0 && q.preset[0] <= q.max_spd
      |=> q.mode == pstls_pkg::PSTLS_PRESET && q.spd_ref == $past(q.preset[0]);
  endproperty
  a_index_pick: assert property (p_index_pick) else $error("preset one not chosen");

  property p_alt_mode;
    s_no_select(`PSTLS_DIGIT_ASPEED) |=> q.mode == pstls_pkg::PSTLS_ASPEED;
  endproperty
  a_alt_mode: assert property (p_alt_mode) else $error("analog speed mode missing");

  property p_position;
    s_no_select(`PSTLS_DIGIT_POSITION) |=> q.mode == pstls_pkg::PSTLS_POSITION ##1
      (q.mode == pstls_pkg::PSTLS_PRESET || $past(sel) == 3'h0);
  endproperty
  a_position: assert property (p_position) else $error("position mode wrong");

  property p_cap_range;
    wr_en && paddr == `PSTLS_OFF_FWD_INT && pwdata > {23'h00_0000, `PSTLS_TRQ_LIMIT}
      |=> q.tcap[`PSTLS_TC_FWD_INT] == `PSTLS_TRQ_LIMIT;
  endproperty
  a_cap_range: assert property (p_cap_range) else $error("cap not saturated");

  property p_fwd_ext;
    fwd_on |=> q.fwd_lim == tmin($past(q.tcap[`PSTLS_TC_FWD_EXT]), $past(q.max_trq));
  endproperty
  a_fwd_ext: assert property (p_fwd_ext) else $error("forward external limit");

  property p_rev_int;
    !rev_on |=> q.rev_lim == tmin($past(q.tcap[`PSTLS_TC_REV_INT]), $past(q.max_trq));
  endproperty
  a_rev_int: assert property (p_rev_int) else $error("reverse internal limit");

  property p_trq_clamp;
    $signed(q.trq_out) <= $signed({1'b0, q.fwd_lim}) &&
      $signed(q.trq_out) >= -$signed({1'b0, q.rev_lim});
  endproperty
  a_trq_clamp: assert property (p_trq_clamp) else $error("torque outside limits");

endmodule // pstls_top

//--- testbench/pstls_host.sv
// host controller side: drives the three contact lines from a wanted index
module pstls_host (
  // clock
  input wire logic pclk,
  // wanted index, bit set means contact closed
  input wire logic [2:0] want_idx,
  // contact lines, low means on
  output logic preset_select_msb_n,
  output logic fwd_limit_select_n,
  output logic rev_limit_select_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // contacts move only after an edge, like a relay output of the host
  always_ff @(posedge pclk) begin
    preset_select_msb_n <= ~want_idx[2];
    fwd_limit_select_n <= ~want_idx[1];
    rev_limit_select_n <= ~want_idx[0];
  end
endmodule // pstls_host

//--- testbench/pstls_bench.sv
`include "pstls_defs.svh"

module preset_speed_torque_limit_select_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic msb_n, fwd_n, rev_n;
  logic [`PSTLS_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] want_idx;
  logic signed [15:0] torque_cmd_in, torque_cmd_out, speed_ref;
  pstls_pkg::pstls_mode_t ctrl_mode;
  logic [8:0] fwd_torque_limit, rev_torque_limit;
  int n_fail, cmp_count, cyc;

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  pstls_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .preset_select_msb_n(msb_n), .fwd_limit_select_n(fwd_n),
    .rev_limit_select_n(rev_n), .torque_cmd_in(torque_cmd_in),
    .torque_cmd_out(torque_cmd_out), .speed_ref(speed_ref), .ctrl_mode(ctrl_mode),
    .fwd_torque_limit(fwd_torque_limit), .rev_torque_limit(rev_torque_limit));

  pstls_host host_u (.pclk(pclk), .want_idx(want_idx), .preset_select_msb_n(msb_n),
    .fwd_limit_select_n(fwd_n), .rev_limit_select_n(rev_n));

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one idle cycle before each setup, so psel is never assigned twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pick(input logic [2:0] k);
    want_idx <= k;
    repeat (3) @(posedge pclk);
  endtask

  task automatic t_defaults();
    int dflt[6] = '{100, 200, 300, -100, -200, -300};
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'h04 + 8'(4 * i), 32'h0000_0000);
      chk("preset reset", 32'(dflt[i]), rd);
    end
    apb(1'b0, `PSTLS_OFF_FWD_INT, 32'h0000_0000);
    chk("fwd int reset", 32'd300, rd);
    apb(1'b0, `PSTLS_OFF_FWD_EXT, 32'h0000_0000);
    chk("fwd ext reset", 32'd100, rd);
    apb(1'b0, `PSTLS_OFF_REV_EXT, 32'h0000_0000);
    chk("rev ext reset", 32'd100, rd);
    $display("test defaults done");
  endtask

  task automatic t_select();
    int exp[8] = '{0, 100, 200, 300, -100, -200, -300, 1234};
    apb(1'b1, 8'h1C, 32'd1234);
    for (int k = 0; k < 8; k++) begin
      pick(3'(k));
      chk("speed_ref", 32'(exp[k]), speed_ref);
      chk("ctrl_mode", (k == 0) ? 32'(pstls_pkg::PSTLS_ZERO) : 32'(pstls_pkg::PSTLS_PRESET),
        ctrl_mode);
    end
    apb(1'b0, `PSTLS_OFF_STATUS, 32'h0000_0000);
    chk("status index", 32'd7, {29'd0, rd[2:0]});
    $display("test select done");
  endtask

  task automatic t_clamp();
    apb(1'b1, 8'h04, 32'd7000);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk("preset saturate", 32'd6000, rd);
    apb(1'b1, 8'h04, 32'd100);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk("preset write", 32'd100, rd);
    apb(1'b1, `PSTLS_OFF_MAX_SPD, 32'd250);
    pick(3'd3);
    chk("speed_ref max", 32'd250, speed_ref);
    pick(3'd6);
    chk("speed_ref max", -32'sd250, speed_ref);
    apb(1'b1, `PSTLS_OFF_MAX_SPD, 32'd6000);
    apb(1'b1, `PSTLS_OFF_CTRL, 32'h0000_0013);
    pick(3'd2);
    chk("speed_ref reversed", -32'sd200, speed_ref);
    $display("test clamp done");
  endtask

  task automatic t_modes();
    apb(1'b1, `PSTLS_OFF_CTRL, 32'h0000_0005);
    pick(3'd0);
    chk("ctrl_mode", 32'(pstls_pkg::PSTLS_POSITION), ctrl_mode);
    pick(3'd5);
    chk("ctrl_mode", 32'(pstls_pkg::PSTLS_PRESET), ctrl_mode);
    chk("speed_ref", -32'sd200, speed_ref);
    apb(1'b1, `PSTLS_OFF_CTRL, 32'h0000_0004);
    pick(3'd0);
    chk("ctrl_mode", 32'(pstls_pkg::PSTLS_ASPEED), ctrl_mode);
    apb(1'b1, `PSTLS_OFF_CTRL, 32'h0000_0006);
    pick(3'd4);
    chk("ctrl_mode", 32'(pstls_pkg::PSTLS_PRESET), ctrl_mode);
    pick(3'd0);
    chk("ctrl_mode", 32'(pstls_pkg::PSTLS_TORQUE), ctrl_mode);
    apb(1'b1, `PSTLS_OFF_CTRL, 32'h0000_0003);
    $display("test modes done");
  endtask

  task automatic t_torque();
    apb(1'b1, `PSTLS_OFF_FWD_EXT, 32'd50);
    torque_cmd_in <= 16'sd80;
    pick(3'd2);
    chk("fwd limit", 32'd50, fwd_torque_limit);
    chk("rev limit", 32'd300, rev_torque_limit);
    chk("torque out", 32'd50, torque_cmd_out);
    torque_cmd_in <= -16'sd400;
    pick(3'd1);
    chk("fwd limit", 32'd300, fwd_torque_limit);
    chk("rev limit", 32'd100, rev_torque_limit);
    chk("torque out", -32'sd100, torque_cmd_out);
    apb(1'b1, `PSTLS_OFF_MAX_TRQ, 32'd200);
    pick(3'd0);
    chk("fwd limit max", 32'd200, fwd_torque_limit);
    chk("torque out", -32'sd200, torque_cmd_out);
    apb(1'b1, `PSTLS_OFF_REV_INT, 32'd7000);
    apb(1'b0, `PSTLS_OFF_REV_INT, 32'h0000_0000);
    chk("rev int saturate", 32'd300, rd);
    apb(1'b1, `PSTLS_OFF_FWD_INT, 32'd7000);
    apb(1'b0, `PSTLS_OFF_FWD_INT, 32'h0000_0000);
    chk("fwd int saturate", 32'd300, rd);
    $display("test torque done");
  endtask

  task automatic t_unmapped();
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped error", 32'd1, {31'd0, err});
    chk("unmapped data", 32'h0000_0000, rd);
    chk("pready", 32'd1, {31'd0, pready});
    $display("test unmapped done");
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    want_idx = 3'd0;
    torque_cmd_in = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_defaults();
    t_select();
    t_clamp();
    t_modes();
    t_torque();
    t_unmapped();
    conclude();
  end
endmodule // preset_speed_torque_limit_select_bench
